// ===== hdl/srx_pkg.sv
package srx_pkg;

  // ---------------------------------------------------------------
  // Register word offsets (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [9:0] CH1_RX_RESULT_CODE_IDX = 10'h258;
  localparam logic [9:0] CH2_RX_RESULT_CODE_IDX = 10'h268;
  localparam logic [9:0] CTRL_IDX               = 10'h300;
  localparam logic [9:0] STATUS_IDX             = 10'h301;
  localparam logic [9:0] MASK_IDX               = 10'h302;
  localparam logic [9:0] ERRCODE_IDX            = 10'h303;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_MODE_W      = 2;
  localparam int CTRL_MCNAK_BIT   = 2;
  localparam int CTRL_LEDCLR_BIT  = 3;
  localparam int CTRL_RXCLR1_BIT  = 4;
  localparam int CTRL_RXCLR2_BIT  = 5;

  localparam int ST_ABN1_BIT  = 0;
  localparam int ST_ABN2_BIT  = 1;
  localparam int ST_RES1_BIT  = 2;
  localparam int ST_RES2_BIT  = 3;
  localparam int ST_LED_BIT   = 4;
  localparam int ST_W         = 5;

  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  localparam logic [15:0] ERRCODE_DEFAULT = 16'h7f01;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Protocol modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRX_MODE_CTRL_ACCESS = 2'b00,
    SRX_MODE_FREE_FORMAT = 2'b01,
    SRX_MODE_BIDIR       = 2'b10,
    SRX_MODE_PREDEF      = 2'b11
  } srx_mode_t;

  typedef enum logic [1:0] {
    SRX_ACT_NONE    = 2'b00,
    SRX_ACT_DISCARD = 2'b01,
    SRX_ACT_NAK     = 2'b10
  } srx_act_t;

endpackage

// ===== hdl/srx_err_if.sv
`timescale 1ns/1ps
`default_nettype none
interface srx_err_if;
  import srx_pkg::*;
  logic      err;
  logic      headSeen;
  srx_mode_t mode;
  logic      mcNak;
  srx_act_t  act;
  logic      setAbn;
  logic      setRes;

  modport top (output err, output headSeen, output mode, output mcNak,
               input act, input setAbn, input setRes);
  modport dec (input err, input headSeen, input mode, input mcNak,
               output act, output setAbn, output setRes);
endinterface
`default_nettype wire

// ===== hdl/srx_err_decide.sv
`timescale 1ns/1ps
`default_nettype none
module srx_err_decide
  import srx_pkg::*;
(
  srx_err_if.dec e
);

  // ---------------------------------------------------------------
  // Reaction to one reception error
  // ---------------------------------------------------------------
  always_comb begin
    e.act    = SRX_ACT_NONE;
    e.setAbn = 1'b0;
    e.setRes = 1'b0;
    if (e.err) begin
      unique case (e.mode)
        SRX_MODE_CTRL_ACCESS: begin
          if (e.headSeen) begin
            e.act = e.mcNak ? SRX_ACT_NAK : SRX_ACT_DISCARD;
          end else begin
            e.act = SRX_ACT_DISCARD;
          end
        end
        SRX_MODE_FREE_FORMAT: begin
          e.setAbn = 1'b1;
        end
        SRX_MODE_BIDIR: begin
          e.act = e.headSeen ? SRX_ACT_NAK : SRX_ACT_DISCARD;
        end
        SRX_MODE_PREDEF: begin
          e.setRes = 1'b1;
        end
      endcase
    end
  end

endmodule // srx_err_decide
`default_nettype wire

// ===== hdl/srx_error_handler.sv
// How it works
// - Controller-access mode, error after head data: discard or answer abnormal end, as set by control.
// - Controller-access mode, error before head data: discard and send no answer.
// - Free-format mode: an error raises the channel's reception-abnormal flag.
// - Bidirectional mode, error after head data: answer abnormal end.
// - Bidirectional mode, error before head data: discard.
// - Predefined mode: the error code goes into the channel's result word at 0x258 or 0x268.
// - Any reception error lights the error indicator until software clears it.
`timescale 1ns/1ps
`default_nettype none
module srx_error_handler
  import srx_pkg::*;
#(
  parameter int NCH = 2
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  rxErr,
  input  wire logic [1:0]  rxHeadSeen,
  output logic      [1:0]  rxDiscard,
  output logic      [1:0]  txAbnormalResp,
  output logic      [1:0]  rxAbnormalFlagPerChannel,
  output logic             errLed,
  output logic             irq
);

  if (NCH != 2) begin : g_nch_check
    $error("srx_error_handler serves exactly two channels");
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic        req;
  logic        wrEn;
  logic [9:0]  idx;
  logic [31:0] wMask;

  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrEn  = req & wb_we_i;
  assign idx   = wb_adr_i[11:2];
  assign wMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic wrHit(input logic [9:0] a);
    wrHit = wrEn && (idx == a);
  endfunction

  // ---------------------------------------------------------------
  // Control and configuration
  // ---------------------------------------------------------------
  logic [1:0]  mode_q;
  logic        mcNak_q;
  logic [15:0] errCode_q;
  logic [ST_W-1:0] mask_q;
  logic [31:0] ctrlW;

  assign ctrlW = wb_dat_i & wMask;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q  <= 2'h0;
      mcNak_q <= 1'b0;
    end else if (wrHit(CTRL_IDX) && wb_sel_i[0]) begin
      mode_q  <= wb_dat_i[CTRL_MODE_LSB +: CTRL_MODE_W];
      mcNak_q <= wb_dat_i[CTRL_MCNAK_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      errCode_q <= ERRCODE_DEFAULT;
    end else if (wrHit(ERRCODE_IDX)) begin
      errCode_q <= (errCode_q & ~wMask[15:0]) | (wb_dat_i[15:0] & wMask[15:0]);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= '0;
    end else if (wrHit(MASK_IDX) && wb_sel_i[0]) begin
      mask_q <= wb_dat_i[ST_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Per-channel decisions
  // ---------------------------------------------------------------
  logic [1:0] setAbn;
  logic [1:0] setRes;
  srx_act_t   act [2];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    srx_err_if e ();
    assign e.err      = rxErr[c];
    assign e.headSeen = rxHeadSeen[c];
    assign e.mode     = srx_mode_t'(mode_q);
    assign e.mcNak    = mcNak_q;
    assign act[c]     = e.act;
    assign setAbn[c]  = e.setAbn;
    assign setRes[c]  = e.setRes;
    srx_err_decide u_dec (
      .e (e.dec)
    );
  end

  // ---------------------------------------------------------------
  // Reaction strobes to the frame logic
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxDiscard      <= 2'b00;
      txAbnormalResp <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        rxDiscard[c]      <= (act[c] == SRX_ACT_DISCARD);
        txAbnormalResp[c] <= (act[c] == SRX_ACT_NAK);
      end
    end
  end

  // ---------------------------------------------------------------
  // Result words
  // ---------------------------------------------------------------
  logic [15:0] result_q [2];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result_q[0] <= RESULT_RESET;
      result_q[1] <= RESULT_RESET;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (setRes[c]) begin
          result_q[c] <= errCode_q;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Abnormal flags: set wins over software clear
  // ---------------------------------------------------------------
  logic [1:0] rxClr;
  assign rxClr[0] = wrHit(CTRL_IDX) && ctrlW[CTRL_RXCLR1_BIT];
  assign rxClr[1] = wrHit(CTRL_IDX) && ctrlW[CTRL_RXCLR2_BIT];

  logic [ST_W-1:0] stat_q;
  logic [ST_W-1:0] statSet;
  logic [ST_W-1:0] statClr;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxAbnormalFlagPerChannel <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (setAbn[c]) begin
          rxAbnormalFlagPerChannel[c] <= 1'b1;
        end else if (rxClr[c] || statClr[ST_ABN1_BIT + c]) begin
          rxAbnormalFlagPerChannel[c] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Error indicator
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      errLed <= 1'b0;
    end else if (|rxErr) begin
      errLed <= 1'b1;
    end else if (wrHit(CTRL_IDX) && ctrlW[CTRL_LEDCLR_BIT]) begin
      errLed <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, write one to clear
  // ---------------------------------------------------------------
  assign statSet = {|rxErr, setRes[1], setRes[0], setAbn[1], setAbn[0]};
  assign statClr = wrHit(STATUS_IDX) ? ctrlW[ST_W-1:0] : '0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
    end else begin
      stat_q <= statSet | (stat_q & ~statClr);
    end
  end

  assign irq = |(stat_q & mask_q);

  // ---------------------------------------------------------------
  // Read data and acknowledge
  // ---------------------------------------------------------------
  logic [31:0] rdData;

  always_comb begin
    rdData = UNMAPPED_READ;
    unique case (idx)
      CH1_RX_RESULT_CODE_IDX: rdData = {16'h0000, result_q[0]};
      CH2_RX_RESULT_CODE_IDX: rdData = {16'h0000, result_q[1]};
      CTRL_IDX:               rdData = {29'h0, mcNak_q, mode_q};
      STATUS_IDX:             rdData = {27'h0, stat_q};
      MASK_IDX:               rdData = {27'h0, mask_q};
      ERRCODE_IDX:            rdData = {16'h0000, errCode_q};
      default:                rdData = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rdData;
      end
    end
  end

endmodule // srx_error_handler
`default_nettype wire

// ===== verification/srx_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module srx_peer_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] req,
  input  wire logic [1:0] head,
  output logic      [1:0] rxErr,
  output logic      [1:0] rxHeadSeen
);
  // One-cycle error event per request, with the head level of that frame
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxErr      <= 2'h0;
      rxHeadSeen <= 2'h0;
    end else begin
      rxErr      <= req;
      rxHeadSeen <= head;
    end
  end
endmodule // srx_peer_model
`default_nettype wire

// ===== verification/srx_error_handler_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module srx_error_handler_asserts
  import srx_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  rxErr,
  input wire logic [1:0]  rxHeadSeen,
  input wire logic [1:0]  rxDiscard,
  input wire logic [1:0]  txAbnormalResp,
  input wire logic [1:0]  rxAbnormalFlagPerChannel,
  input wire logic        errLed
);
  logic [1:0] mode_q;
  logic       nak_q;
  // Shadow of the mode field, taken from completed writes
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) {nak_q, mode_q} <= 3'h0;
    else if (wb_we_i && wb_ack_o && wb_adr_i[11:2] == CTRL_IDX) {nak_q, mode_q} <= wb_dat_i[2:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_ca_head: assert property (mode_q == 2'h0 && rxErr[0] && rxHeadSeen[0]
    |=> (nak_q ? txAbnormalResp[0] : rxDiscard[0])) else $error("head error answer wrong");
  a_ca_nohead: assert property (mode_q == 2'h0 && rxErr[0] && !rxHeadSeen[0]
    |=> rxDiscard[0] && !txAbnormalResp[0]) else $error("early error not discarded");
  a_free_flag: assert property (mode_q == 2'h1 && rxErr[1]
    |=> rxAbnormalFlagPerChannel[1] && !rxDiscard[1] && !txAbnormalResp[1]) else $error("flag not raised");
  a_bd_head: assert property (mode_q == 2'h2 && rxErr[0] && rxHeadSeen[0]
    |=> txAbnormalResp[0] && !rxDiscard[0]) else $error("no abnormal answer");
  a_bd_nohead: assert property (mode_q == 2'h2 && rxErr[1] && !rxHeadSeen[1]
    |=> rxDiscard[1] && !txAbnormalResp[1]) else $error("early error kept");
  a_pd_quiet: assert property (mode_q == 2'h3 && rxErr[0]
    |=> !rxDiscard[0] && !txAbnormalResp[0]) else $error("predef mode answered");
  a_led_on: assert property (rxErr != 2'h0 |=> errLed) else $error("indicator not lit");
  a_led_hold: assert property ($fell(errLed)
    |-> (wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o)) else $error("indicator dropped");
  a_flag_hold: assert property ($fell(rxAbnormalFlagPerChannel[0])
    |-> (wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o)) else $error("flag dropped");
endmodule // srx_error_handler_asserts
bind srx_error_handler srx_error_handler_asserts u_asserts (.ref_clk(ref_clk), .rstn(rstn),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .rxErr(rxErr),
  .rxHeadSeen(rxHeadSeen), .rxDiscard(rxDiscard), .txAbnormalResp(txAbnormalResp),
  .rxAbnormalFlagPerChannel(rxAbnormalFlagPerChannel), .errLed(errLed));
`default_nettype wire

// ===== verification/srx_error_handler_test.sv
`timescale 1ns/1ps
`default_nettype none
module srx_error_handler_test
  import srx_pkg::*;
;
  logic        ref_clk, rstn, cyc, stb, we, ack, errLed, irq;
  logic [11:0] adr;
  logic [31:0] dat, rdat;
  logic [1:0]  req, head, rxErr, rxHeadSeen, disc, abn, flag, rxDiscard, txAbnormalResp;
  int          mismatches, checked, cycles;
  srx_peer_model peer (.ref_clk(ref_clk), .rstn(rstn), .req(req), .head(head), .rxErr(rxErr),
    .rxHeadSeen(rxHeadSeen));
  srx_error_handler DUT (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .rxErr(rxErr),
    .rxHeadSeen(rxHeadSeen), .rxDiscard(rxDiscard), .txAbnormalResp(txAbnormalResp),
    .rxAbnormalFlagPerChannel(flag), .errLed(errLed), .irq(irq));
  task stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [9:0] ix, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    {cyc, stb, we} <= {2'h3, w};
    adr <= {ix, 2'h0};
    dat <= wd;
    do @(posedge ref_clk); while (ack !== 1'h1);
    rd = rdat;
    {cyc, stb, we} <= 3'h0;
  endtask
  task wr(input logic [9:0] ix, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'h1, ix, wd, x);
  endtask
  task rdc(input string n, input logic [9:0] ix, input logic [31:0] e);
    logic [31:0] x;
    bus(1'h0, ix, 32'h0, x);
    chk(n, x, e);
  endtask
  // Error event on the chosen channels; the answer stands in the cycle after
  task hit(input logic [1:0] ch, input logic [1:0] hd);
    @(posedge ref_clk);
    req  <= ch;
    head <= hd;
    @(posedge ref_clk);
    req <= 2'h0;
    @(posedge ref_clk);
    #1;
    disc = rxDiscard;
    abn  = txAbnormalResp;
  endtask
  task settle;
    @(posedge ref_clk);
    #1;
  endtask
  task t_reset;
    chk("outputs", 32'({rxDiscard, txAbnormalResp, flag, errLed, irq}), 32'h0);
    rdc("result1", CH1_RX_RESULT_CODE_IDX, 32'h0);
    rdc("result2", CH2_RX_RESULT_CODE_IDX, 32'h0);
    rdc("code", ERRCODE_IDX, {16'h0, ERRCODE_DEFAULT});
    rdc("unmapped", 10'h3ff, UNMAPPED_READ);
  endtask
  task t_ctrl;
    wr(CTRL_IDX, 32'h0);
    hit(2'h1, 2'h1);
    chk("ca discard", 32'({abn, disc}), 32'h1);
    wr(CTRL_IDX, 32'h4);
    rdc("ctrl", CTRL_IDX, 32'h4);
    hit(2'h2, 2'h2);
    chk("ca answer", 32'({abn, disc}), 32'h8);
    hit(2'h3, 2'h0);
    chk("ca early", 32'({abn, disc}), 32'h3);
  endtask
  task t_bidir;
    wr(CTRL_IDX, 32'h2);
    hit(2'h3, 2'h1);
    chk("bidir", 32'({abn, disc}), 32'h6);
  endtask
  task t_predef;
    wr(CTRL_IDX, 32'h3);
    wr(ERRCODE_IDX, 32'h0123);
    hit(2'h1, 2'h0);
    rdc("pd res1", CH1_RX_RESULT_CODE_IDX, 32'h0123);
    wr(ERRCODE_IDX, 32'h0456);
    hit(2'h2, 2'h1);
    rdc("pd res2", CH2_RX_RESULT_CODE_IDX, 32'h0456);
    rdc("pd keep", CH1_RX_RESULT_CODE_IDX, 32'h0123);
  endtask
  task t_free;
    wr(CTRL_IDX, 32'h1);
    wr(STATUS_IDX, 32'h1f);
    hit(2'h2, 2'h2);
    chk("free quiet", 32'({abn, disc}), 32'h0);
    repeat (6) settle();
    chk("flag hold", 32'(flag), 32'h2);
    wr(CTRL_IDX, 32'h21);
    settle();
    chk("flag clr", 32'(flag), 32'h0);
    hit(2'h1, 2'h0);
    rdc("status", STATUS_IDX, 32'h13);
    wr(MASK_IDX, 32'h0);
    settle();
    chk("irq off", 32'(irq), 32'h0);
    wr(MASK_IDX, 32'h1f);
    rdc("mask", MASK_IDX, 32'h1f);
    settle();
    chk("irq on", 32'(irq), 32'h1);
    wr(STATUS_IDX, 32'h1);
    settle();
    chk("flag w1c", 32'(flag), 32'h0);
    chk("led hold", 32'(errLed), 32'h1);
    wr(CTRL_IDX, 32'h9);
    wr(STATUS_IDX, 32'h1f);
    wr(MASK_IDX, 32'h0);
    settle();
    chk("led clr", 32'({errLed, irq}), 32'h0);
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    {rstn, cyc, stb, we, req, head, adr, dat} = '0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'h1;
    t_reset();
    t_ctrl();
    t_bidir();
    t_predef();
    t_free();
    stop_test();
  end
endmodule // srx_error_handler_test
`default_nettype wire
